//--- shared/pin_steer_cfg.svh
`ifndef PIN_STEER_CFG_SVH
`define PIN_STEER_CFG_SVH

// ==========================================================
// register map, byte addresses on the 8-bit register port
// ==========================================================
`define ADDR_DIR_BASE     8'h00
`define ADDR_LAT_BASE     8'h04
`define ADDR_LVL_BASE     8'h08
`define ADDR_ANS_BASE     8'h0C
`define ADDR_STEER0       8'h10
`define ADDR_STEER1       8'h11
`define KIND_DIR          2'h0
`define KIND_LAT          2'h1
`define KIND_LVL          2'h2
`define KIND_ANS          2'h3
`define PORT_IDX_A        2'h0
`define PORT_IDX_B        2'h1
`define PORT_IDX_C        2'h2

// ==========================================================
// reset values
// ==========================================================
`define DIR_RESET         8'hFF
`define LAT_RESET         8'h00
`define ANS_RESET         8'hFF
`define STEER_RESET       8'h00

// ==========================================================
// implemented bits per variant
// ==========================================================
`define STEER0_MASK_14    8'hEC
`define STEER0_MASK_20    8'h8C
`define STEER1_MASK_14    8'h0F
`define STEER1_MASK_20    8'h3F
`define PORT_A_MASK       8'h3F
`define PORT_B_MASK_14    8'h00
`define PORT_B_MASK_20    8'hF0
`define PORT_C_MASK_14    8'h3F
`define PORT_C_MASK_20    8'hFF

// ==========================================================
// steering field positions
// ==========================================================
`define BIT_UART_RX       7
`define BIT_SPI_OUT       6
`define BIT_SPI_SEL       5
`define BIT_TIMER_GATE    3
`define BIT_UART_TX       2
`define BIT_SPI2_OUT      5
`define BIT_SPI2_SEL      4
`define BIT_PWM1_D        3
`define BIT_PWM2_B        1
`define BIT_CAPTURE2      0

// ==========================================================
// flat pin indices: port a 0..7, port b 8..15, port c 16..23
// ==========================================================
`define PIN_A0            5'h00
`define PIN_A1            5'h01
`define PIN_A3            5'h03
`define PIN_A4            5'h04
`define PIN_A5            5'h05
`define PIN_B5            5'h0D
`define PIN_B7            5'h0F
`define PIN_C0            5'h10
`define PIN_C1            5'h11
`define PIN_C2            5'h12
`define PIN_C3            5'h13
`define PIN_C4            5'h14
`define PIN_C5            5'h15
`define PIN_C6            5'h16
`define PIN_C7            5'h17

`endif

//--- shared/pin_steer_pkg.sv
package pin_steer_pkg;
  typedef logic [7:0]  byte_type;
  typedef logic [23:0] pin_vec_type;
  typedef logic [4:0]  pin_idx_type;
endpackage

//--- core/port_bank.sv
`timescale 1ns/1ns
`include "pin_steer_cfg.svh"

module port_bank #(
  parameter int                  WIDTH     = 8,
  parameter pin_steer_pkg::byte_type IMPL_MASK = 8'hFF
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     sys_rst_in,
  input  wire pin_steer_pkg::byte_type  wdata_in,
  input  wire logic                     dir_wr_in,
  input  wire logic                     lat_wr_in,
  input  wire logic                     ans_wr_in,
  input  wire pin_steer_pkg::byte_type  pin_in,
  input  wire pin_steer_pkg::byte_type  ovr_en_in,
  input  wire pin_steer_pkg::byte_type  ovr_oe_in,
  input  wire pin_steer_pkg::byte_type  ovr_data_in,
  output logic [7:0]                    dir_out,
  output logic [7:0]                    lat_out,
  output logic [7:0]                    ans_out,
  output logic [7:0]                    level_out,
  output logic [7:0]                    dig_out,
  output logic [7:0]                    pin_out,
  output logic [7:0]                    pin_oe_out
);
  if (WIDTH != 8) begin : g_width_check
    $error("port_bank serves 8-bit ports only");
  end

  logic [7:0] dir_reg;
  logic [7:0] lat_reg;
  logic [7:0] ans_reg;
  logic [7:0] level_reg;
  logic [7:0] out_reg;
  logic [7:0] oe_reg;
  wire  [7:0] out_next;
  wire  [7:0] oe_next;

  // analog select blocks the digital input path
  assign dig_out  = pin_in & ~ans_reg & IMPL_MASK;
  // peripheral override wins; otherwise direction bit 0 drives the latch
  assign out_next = ((ovr_en_in & ovr_data_in) | (~ovr_en_in & lat_reg)) & IMPL_MASK;
  assign oe_next  = ((ovr_en_in & ovr_oe_in) | (~ovr_en_in & ~dir_reg)) & IMPL_MASK;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dir_reg   <= `DIR_RESET & IMPL_MASK;
      lat_reg   <= `LAT_RESET;
      ans_reg   <= `ANS_RESET & IMPL_MASK;
      level_reg <= 8'h00;
      out_reg   <= 8'h00;
      oe_reg    <= 8'h00;
    end else begin
      if (dir_wr_in) begin
        dir_reg <= wdata_in & IMPL_MASK;
      end
      if (lat_wr_in) begin
        lat_reg <= wdata_in & IMPL_MASK;
      end
      if (ans_wr_in) begin
        ans_reg <= wdata_in & IMPL_MASK;
      end
      level_reg <= dig_out;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
    end
  end

  assign dir_out    = dir_reg;
  assign lat_out    = lat_reg;
  assign ans_out    = ans_reg;
  assign level_out  = level_reg;
  assign pin_out    = out_reg;
  assign pin_oe_out = oe_reg;
endmodule

//--- core/steer_decode.sv
`timescale 1ns/1ns
`include "pin_steer_cfg.svh"

module steer_decode #(
  parameter int PIN_COUNT = 14
) (
  input  wire pin_steer_pkg::byte_type    steer0_in,
  input  wire pin_steer_pkg::byte_type    steer1_in,
  input  wire logic [5:0]                 src_en_in,
  input  wire logic [5:0]                 src_oe_in,
  input  wire logic [5:0]                 src_data_in,
  input  wire pin_steer_pkg::pin_vec_type dig_in,
  output pin_steer_pkg::pin_vec_type      ovr_en_out,
  output pin_steer_pkg::pin_vec_type      ovr_oe_out,
  output pin_steer_pkg::pin_vec_type      ovr_data_out,
  output logic                            uart_rx_out,
  output logic                            spi_select_out,
  output logic                            spi2_select_out,
  output logic                            timer_gate_out,
  output logic                            capture2_out
);
  localparam bit WIDE = (PIN_COUNT == 20);

  function automatic pin_steer_pkg::pin_idx_type pin_pick(input logic sel,
                                                          input pin_steer_pkg::pin_idx_type p0,
                                                          input pin_steer_pkg::pin_idx_type p1);
    return sel ? p1 : p0;
  endfunction

  // source order 0..5: uart tx, spi out, spi2 out, pwm1 d, pwm2 b, capture2
  pin_steer_pkg::pin_idx_type src_pin [6];
  wire pin_steer_pkg::pin_idx_type rx_pin;
  wire pin_steer_pkg::pin_idx_type sel_pin;
  wire pin_steer_pkg::pin_idx_type sel2_pin;
  wire pin_steer_pkg::pin_idx_type gate_pin;

  assign rx_pin = WIDE ? pin_pick(steer0_in[`BIT_UART_RX], `PIN_B5, `PIN_C5)
                       : pin_pick(steer0_in[`BIT_UART_RX], `PIN_C5, `PIN_A1);
  assign src_pin[1] = WIDE ? `PIN_C7 : pin_pick(steer0_in[`BIT_SPI_OUT], `PIN_C2, `PIN_A4);
  assign sel_pin = WIDE ? `PIN_C6 : pin_pick(steer0_in[`BIT_SPI_SEL], `PIN_C3, `PIN_A3);
  assign gate_pin = pin_pick(steer0_in[`BIT_TIMER_GATE], `PIN_A4, `PIN_A3);
  assign src_pin[0] = WIDE ? pin_pick(steer0_in[`BIT_UART_TX], `PIN_B7, `PIN_C4)
                           : pin_pick(steer0_in[`BIT_UART_TX], `PIN_C4, `PIN_A0);
  assign src_pin[2] = pin_pick(steer1_in[`BIT_SPI2_OUT], `PIN_C1, `PIN_A5);
  assign sel2_pin = pin_pick(steer1_in[`BIT_SPI2_SEL], `PIN_C0, `PIN_A4);
  assign src_pin[3] = pin_pick(steer1_in[`BIT_PWM1_D], `PIN_C2, `PIN_C0);
  assign src_pin[4] = pin_pick(steer1_in[`BIT_PWM2_B], `PIN_C2, `PIN_A4);
  assign src_pin[5] = pin_pick(steer1_in[`BIT_CAPTURE2], `PIN_C3, `PIN_A5);

  assign uart_rx_out     = dig_in[rx_pin];
  assign spi_select_out  = dig_in[sel_pin];
  // second spi exists only on the wide variant
  assign spi2_select_out = WIDE ? dig_in[sel2_pin] : 1'b0;
  assign timer_gate_out  = dig_in[gate_pin];
  assign capture2_out    = dig_in[src_pin[5]];

  // lower source number wins a shared pin; only the selected pin is touched
  always_comb begin
    ovr_en_out   = '0;
    ovr_oe_out   = '0;
    ovr_data_out = '0;
    for (int k = 5; k >= 0; k--) begin
      if (src_en_in[k] && (WIDE || k != 2)) begin
        ovr_en_out[src_pin[k]]   = 1'b1;
        ovr_oe_out[src_pin[k]]   = src_oe_in[k];
        ovr_data_out[src_pin[k]] = src_data_in[k];
      end
    end
  end
endmodule

//--- core/pin_steer_top.sv
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "pin_steer_cfg.svh"

module pin_steer_top #(
  parameter int PIN_COUNT = 14
) (
  input  wire logic                    clk_sys_in,
  input  wire logic                    sys_rst_in,
  input  wire pin_steer_pkg::byte_type reg_addr_in,
  input  wire pin_steer_pkg::byte_type reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output pin_steer_pkg::byte_type      reg_rdata_out,
  input  wire pin_steer_pkg::byte_type pin_a_in,
  input  wire pin_steer_pkg::byte_type pin_b_in,
  input  wire pin_steer_pkg::byte_type pin_c_in,
  output pin_steer_pkg::byte_type      pin_a_out,
  output pin_steer_pkg::byte_type      pin_a_oe_out,
  output pin_steer_pkg::byte_type      pin_b_out,
  output pin_steer_pkg::byte_type      pin_b_oe_out,
  output pin_steer_pkg::byte_type      pin_c_out,
  output pin_steer_pkg::byte_type      pin_c_oe_out,
  input  wire logic                    uart_tx_line_in,
  input  wire logic                    uart_tx_en_in,
  input  wire logic                    spi_data_out_in,
  input  wire logic                    spi_out_en_in,
  input  wire logic                    spi2_data_out_in,
  input  wire logic                    spi2_out_en_in,
  input  wire logic                    pwm1_out_d_in,
  input  wire logic                    pwm1_d_en_in,
  input  wire logic                    pwm2_out_b_in,
  input  wire logic                    pwm2_b_en_in,
  input  wire logic                    capture2_io_in,
  input  wire logic                    capture2_oe_in,
  input  wire logic                    capture2_en_in,
  output logic                         uart_rx_line_out,
  output logic                         spi_select_out,
  output logic                         spi2_select_out,
  output logic                         timer_gate_out,
  output logic                         capture2_io_out
);
  // ==========================================================
  // variant
  // ==========================================================
  if (PIN_COUNT != 14 && PIN_COUNT != 20) begin : g_variant_check
    $error("PIN_COUNT must be 14 or 20");
  end

  localparam bit WIDE = (PIN_COUNT == 20);
  localparam pin_steer_pkg::byte_type STEER0_MASK = WIDE ? `STEER0_MASK_20 : `STEER0_MASK_14;
  localparam pin_steer_pkg::byte_type STEER1_MASK = WIDE ? `STEER1_MASK_20 : `STEER1_MASK_14;
  localparam pin_steer_pkg::byte_type B_MASK      = WIDE ? `PORT_B_MASK_20 : `PORT_B_MASK_14;
  localparam pin_steer_pkg::byte_type C_MASK      = WIDE ? `PORT_C_MASK_20 : `PORT_C_MASK_14;

  // ==========================================================
  // address decode
  // ==========================================================
  wire       port_space = (reg_addr_in[7:4] == 4'h0) && (reg_addr_in[1:0] != 2'h3);
  wire [1:0] kind       = reg_addr_in[3:2];
  wire [1:0] port_idx   = reg_addr_in[1:0];
  wire       hit_steer0 = (reg_addr_in == `ADDR_STEER0);
  wire       hit_steer1 = (reg_addr_in == `ADDR_STEER1);
  wire [2:0] port_sel;
  wire [2:0] dir_wr;
  wire [2:0] lat_wr;
  wire [2:0] ans_wr;

  for (genvar p = 0; p < 3; p++) begin : g_wr
    assign port_sel[p] = port_space && (port_idx == 2'(p));
    assign dir_wr[p]   = reg_wr_in && port_sel[p] && (kind == `KIND_DIR);
    // pin level writes land in the latch, same as latch writes
    assign lat_wr[p]   = reg_wr_in && port_sel[p] && (kind == `KIND_LAT || kind == `KIND_LVL);
    assign ans_wr[p]   = reg_wr_in && port_sel[p] && (kind == `KIND_ANS);
  end

  // ==========================================================
  // steering registers
  // ==========================================================
  pin_steer_pkg::byte_type steer0_reg;
  pin_steer_pkg::byte_type steer1_reg;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      steer0_reg <= `STEER_RESET;
      steer1_reg <= `STEER_RESET;
    end else begin
      if (reg_wr_in && hit_steer0) begin
        steer0_reg <= reg_wdata_in & STEER0_MASK;
      end
      if (reg_wr_in && hit_steer1) begin
        steer1_reg <= reg_wdata_in & STEER1_MASK;
      end
    end
  end

  // ==========================================================
  // port banks and steering
  // ==========================================================
  pin_steer_pkg::byte_type dir_v [3];
  pin_steer_pkg::byte_type lat_v [3];
  pin_steer_pkg::byte_type ans_v [3];
  pin_steer_pkg::byte_type lvl_v [3];
  pin_steer_pkg::byte_type dig_v [3];
  pin_steer_pkg::pin_vec_type ovr_en;
  pin_steer_pkg::pin_vec_type ovr_oe;
  pin_steer_pkg::pin_vec_type ovr_data;
  wire pin_steer_pkg::pin_vec_type dig_all = {dig_v[2], dig_v[1], dig_v[0]};
  logic rx_next;
  logic sel_next;
  logic sel2_next;
  logic gate_next;
  logic cap_next;

  port_bank #(.WIDTH(8), .IMPL_MASK(`PORT_A_MASK)) u_bank_a (
    .clk_sys_in  (clk_sys_in),
    .sys_rst_in  (sys_rst_in),
    .wdata_in    (reg_wdata_in),
    .dir_wr_in   (dir_wr[0]),
    .lat_wr_in   (lat_wr[0]),
    .ans_wr_in   (ans_wr[0]),
    .pin_in      (pin_a_in),
    .ovr_en_in   (ovr_en[7:0]),
    .ovr_oe_in   (ovr_oe[7:0]),
    .ovr_data_in (ovr_data[7:0]),
    .dir_out     (dir_v[0]),
    .lat_out     (lat_v[0]),
    .ans_out     (ans_v[0]),
    .level_out   (lvl_v[0]),
    .dig_out     (dig_v[0]),
    .pin_out     (pin_a_out),
    .pin_oe_out  (pin_a_oe_out)
  );

  port_bank #(.WIDTH(8), .IMPL_MASK(B_MASK)) u_bank_b (
    .clk_sys_in  (clk_sys_in),
    .sys_rst_in  (sys_rst_in),
    .wdata_in    (reg_wdata_in),
    .dir_wr_in   (dir_wr[1]),
    .lat_wr_in   (lat_wr[1]),
    .ans_wr_in   (ans_wr[1]),
    .pin_in      (pin_b_in),
    .ovr_en_in   (ovr_en[15:8]),
    .ovr_oe_in   (ovr_oe[15:8]),
    .ovr_data_in (ovr_data[15:8]),
    .dir_out     (dir_v[1]),
    .lat_out     (lat_v[1]),
    .ans_out     (ans_v[1]),
    .level_out   (lvl_v[1]),
    .dig_out     (dig_v[1]),
    .pin_out     (pin_b_out),
    .pin_oe_out  (pin_b_oe_out)
  );

  port_bank #(.WIDTH(8), .IMPL_MASK(C_MASK)) u_bank_c (
    .clk_sys_in  (clk_sys_in),
    .sys_rst_in  (sys_rst_in),
    .wdata_in    (reg_wdata_in),
    .dir_wr_in   (dir_wr[2]),
    .lat_wr_in   (lat_wr[2]),
    .ans_wr_in   (ans_wr[2]),
    .pin_in      (pin_c_in),
    .ovr_en_in   (ovr_en[23:16]),
    .ovr_oe_in   (ovr_oe[23:16]),
    .ovr_data_in (ovr_data[23:16]),
    .dir_out     (dir_v[2]),
    .lat_out     (lat_v[2]),
    .ans_out     (ans_v[2]),
    .level_out   (lvl_v[2]),
    .dig_out     (dig_v[2]),
    .pin_out     (pin_c_out),
    .pin_oe_out  (pin_c_oe_out)
  );

  steer_decode #(.PIN_COUNT(PIN_COUNT)) u_decode (
    .steer0_in       (steer0_reg),
    .steer1_in       (steer1_reg),
    .src_en_in       ({capture2_en_in, pwm2_b_en_in, pwm1_d_en_in,
                       spi2_out_en_in, spi_out_en_in, uart_tx_en_in}),
    .src_oe_in       ({capture2_oe_in, 5'h1F}),
    .src_data_in     ({capture2_io_in, pwm2_out_b_in, pwm1_out_d_in,
                       spi2_data_out_in, spi_data_out_in, uart_tx_line_in}),
    .dig_in          (dig_all),
    .ovr_en_out      (ovr_en),
    .ovr_oe_out      (ovr_oe),
    .ovr_data_out    (ovr_data),
    .uart_rx_out     (rx_next),
    .spi_select_out  (sel_next),
    .spi2_select_out (sel2_next),
    .timer_gate_out  (gate_next),
    .capture2_out    (cap_next)
  );

  // ==========================================================
  // read path and peripheral inputs
  // ==========================================================
  wire pin_steer_pkg::byte_type port_word =
    (kind == `KIND_DIR) ? dir_v[port_idx] :
    (kind == `KIND_LAT) ? lat_v[port_idx] :
    (kind == `KIND_LVL) ? lvl_v[port_idx] : ans_v[port_idx];
  // unmapped addresses read zero rather than stalling the master
  wire pin_steer_pkg::byte_type reg_rdata_next =
    !reg_rd_in ? 8'h00 :
    port_space ? port_word :
    hit_steer0 ? steer0_reg :
    hit_steer1 ? steer1_reg : 8'h00;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out    <= 8'h00;
      uart_rx_line_out <= 1'b0;
      spi_select_out   <= 1'b0;
      spi2_select_out  <= 1'b0;
      timer_gate_out   <= 1'b0;
      capture2_io_out  <= 1'b0;
    end else begin
      reg_rdata_out    <= reg_rdata_next;
      uart_rx_line_out <= rx_next;
      spi_select_out   <= sel_next;
      spi2_select_out  <= sel2_next;
      timer_gate_out   <= gate_next;
      capture2_io_out  <= cap_next;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  chk_lat_alias: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == (`ADDR_LVL_BASE | 8'h02) |=> lat_v[2] == ($past(reg_wdata_in) & C_MASK))
    else $error("pin level write missed the latch");

  chk_level_read: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    reg_rd_in && reg_addr_in == `ADDR_LVL_BASE |=> reg_rdata_out == $past(lvl_v[0]))
    else $error("pin level read wrong");

  // a read right behind keeps the data up, so only a lone read must drop to zero
  chk_latch_read: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    reg_rd_in && reg_addr_in == `ADDR_LAT_BASE ##1 !reg_rd_in
      |-> reg_rdata_out == $past(lat_v[0]) ##1 reg_rdata_out == 8'h00)
    else $error("latch read wrong or held too long");

  chk_dir_kept: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    reg_wr_in && (hit_steer0 || hit_steer1) |=> $stable(dir_v[0]) && $stable(dir_v[2]))
    else $error("steering write moved a direction bit");

  chk_unselected_pin: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !WIDE && !spi_out_en_in && !pwm2_b_en_in && !pwm1_d_en_in && !uart_tx_en_in
      |=> pin_c_oe_out[2] == !$past(dir_v[2][2]) && pin_c_out[2] == $past(lat_v[2][2]))
    else $error("unselected pin lost port behaviour");

  chk_tx_takes_pin: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !WIDE && uart_tx_en_in && steer0_reg[`BIT_UART_TX] |=> pin_a_oe_out[0] && pin_a_out[0] == $past(uart_tx_line_in))
    else $error("uart transmit not on selected pin");

  chk_analog_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ans_v[0][1] |=> !lvl_v[0][1])
    else $error("analog pin read non-zero");

  chk_rx_route: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !WIDE && steer0_reg[`BIT_UART_RX] && !ans_v[0][1] |=> uart_rx_line_out == $past(pin_a_in[1]))
    else $error("uart receive taken from wrong pin");

  chk_steer_ro_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    reg_rd_in && hit_steer0 |=> (reg_rdata_out & ~STEER0_MASK) == 8'h00)
    else $error("unimplemented steering bit reads one");

  chk_gate_route: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    steer0_reg[`BIT_TIMER_GATE] |=> timer_gate_out == $past(pin_a_in[3] & ~ans_v[0][3]))
    else $error("timer gate taken from wrong pin");

  chk_spi_out_pin: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !WIDE && spi_out_en_in && !steer0_reg[`BIT_SPI_OUT]
      |=> pin_c_oe_out[2] && pin_c_out[2] == $past(spi_data_out_in))
    else $error("spi output not on selected pin");

  chk_pwm1_pin: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    pwm1_d_en_in && !spi_out_en_in && !steer1_reg[`BIT_PWM1_D]
      |=> pin_c_oe_out[2] && pin_c_out[2] == $past(pwm1_out_d_in))
    else $error("pwm1 d output not on selected pin");

  chk_dir_drives: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !ovr_en[2] |=> pin_a_oe_out[2] == !$past(dir_v[0][2]) && pin_a_out[2] == $past(lat_v[0][2]))
    else $error("direction bit did not steer the driver");
endmodule

//--- sim/pin_partner.sv
`timescale 1ns/1ns

// ==========================================================
// package pins: driven where enabled, outside world elsewhere
// ==========================================================
module pin_partner (
  input  wire pin_steer_pkg::pin_vec_type out_in,
  input  wire pin_steer_pkg::pin_vec_type oe_in,
  input  wire pin_steer_pkg::pin_vec_type ext_in,
  output pin_steer_pkg::pin_vec_type      pin_out
);
  // a released pin shows the outside level, never the last driven one
  assign pin_out = (out_in & oe_in) | (ext_in & ~oe_in);
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ns

module tb_top;
  logic                       clk_sys_in, sys_rst_in, wr, rd, rd_seen, rx, gate, ssel, ssel2, cap;
  pin_steer_pkg::byte_type    addr, wdata, rdata;
  pin_steer_pkg::pin_vec_type pout, poe, pin, ext;
  logic [12:0]                per;
  logic [15:0]                lfsr;
  pin_steer_pkg::byte_type    exp_q[$];
  int                         n_fail, comparisons, cyc;

  pin_steer_top #(.PIN_COUNT(14)) u_dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .pin_a_in(pin[7:0]), .pin_b_in(pin[15:8]), .pin_c_in(pin[23:16]),
    .pin_a_out(pout[7:0]), .pin_a_oe_out(poe[7:0]), .pin_b_out(pout[15:8]), .pin_b_oe_out(poe[15:8]),
    .pin_c_out(pout[23:16]), .pin_c_oe_out(poe[23:16]),
    .uart_tx_line_in(per[0]), .uart_tx_en_in(per[1]), .spi_data_out_in(per[2]), .spi_out_en_in(per[3]),
    .spi2_data_out_in(per[4]), .spi2_out_en_in(per[5]), .pwm1_out_d_in(per[6]), .pwm1_d_en_in(per[7]),
    .pwm2_out_b_in(per[8]), .pwm2_b_en_in(per[9]), .capture2_io_in(per[10]), .capture2_oe_in(per[11]),
    .capture2_en_in(per[12]), .uart_rx_line_out(rx), .spi_select_out(ssel), .spi2_select_out(ssel2),
    .timer_gate_out(gate), .capture2_io_out(cap));

  pin_partner u_pins (.out_in(pout), .oe_in(poe), .ext_in(ext), .pin_out(pin));

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // register port master
  // ==========================================================
  task automatic wrreg(input pin_steer_pkg::byte_type a, input pin_steer_pkg::byte_type d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask

  task automatic rdreg(input pin_steer_pkg::byte_type a, input pin_steer_pkg::byte_type e);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys_in);
    rd <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys_in) rd_seen <= rd;
  always @(negedge clk_sys_in) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) check(rdata, exp_q.pop_front());
  end

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    sys_rst_in = 1'b1;
    {wr, rd, addr, wdata, per, ext} = '0;
    lfsr = 16'h7EB6;
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rdreg(8'h00, 8'h3F);
    rdreg(8'h0C, 8'h3F);
    rdreg(8'h11, 8'h00);
    rdreg(8'h03, 8'h00);
    wrreg(8'h10, 8'hFF);
    rdreg(8'h10, 8'hEC);
    wrreg(8'h11, 8'hFF);
    rdreg(8'h11, 8'h0F);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wrreg(i[0] ? 8'h08 : 8'h04, lfsr[7:0]);
      rdreg(8'h04, lfsr[7:0] & 8'h3F);
    end
    wrreg(8'h04, 8'h3E);
    wrreg(8'h00, 8'h00);
    wrreg(8'h10, 8'h04);
    settle();
    check({poe[7:0], pout[7:0]}, 16'h3F3E);
    per <= 13'h0003;
    settle();
    check({poe[0], pout[0]}, 2'b11);
    check(poe[20], 1'b0);
    wrreg(8'h10, 8'h00);
    settle();
    check({poe[0], pout[0], poe[20], pout[20]}, 4'hB);
    rdreg(8'h00, 8'h00);
    wrreg(8'h00, 8'hFF);
    wrreg(8'h0C, 8'h00);
    wrreg(8'h0E, 8'h00);
    lfsr = nxt(lfsr);
    ext <= {lfsr[7:0], lfsr};
    settle();
    check(rx, ext[21]);
    rdreg(8'h08, ext[7:0] & 8'h3F);
    wrreg(8'h10, 8'h80);
    settle();
    check(rx, ext[1]);
    check(gate, ext[4]);
    check(ssel, ext[19]);
    check(cap, ext[5]);
    check(ssel2, 1'b0);
    wrreg(8'h10, 8'hA8);
    settle();
    check(gate, ext[3]);
    check(ssel, ext[3]);
    wrreg(8'h0C, 8'h0F);
    settle();
    check(rx, 1'b0);
    rdreg(8'h08, ext[7:0] & 8'h30);
    per <= 13'h1F8C;
    settle();
    check({poe[18], pout[18]}, 2'b11);
    check({poe[16], pout[16]}, 2'b10);
    check({poe[4], pout[4]}, 2'b11);
    check({poe[5], pout[5]}, 2'b11);
    wrreg(8'h11, 8'h00);
    settle();
    check({poe[18], pout[18]}, 2'b11);
    check({poe[19], pout[19]}, 2'b11);
    check({poe[16], poe[5:4]}, 3'b000);
    per <= 13'h00C0;
    settle();
    check({poe[18], pout[18], poe[19]}, 3'b110);
    give_verdict();
  end
endmodule
